// file: verilog/ssp_sync_serial.sv
// Clock synchronous serial port: APB registers, rate divider, shifter.
// Assumes APB master on pclk, external pins async to pclk.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// Functional notes
// - Every frame is exactly eight data bits, no framing bits.
// - Internal clock is count source divided by 2(n+1).
// - With clock direction one, the clock pin input clocks transfers.
// - Transmit starts on enable, full buffer and low clear-to-send.
// - Receive needs receive enable, transmit enable and full buffer.
// - Polarity zero drives on falling, samples rising; one reverses.
// - Transmit request on buffer move or on shift end, by source bit.
// - Receive request and complete flag on move into receive buffer.
// - Overrun set at seventh bit of a frame received while the receive buffer is still unread.
// - Overrun frame gives no receive request.
// - Bit order select picks LSB first or MSB first both ways.
// - Continuous receive: buffer read clears transmit buffer empty.
// - Inversion flips every transmitted and received data bit.
// - Data out holds its last bit between frames; high bits float when open drain selected.
// - Mode field 001b enables the port, 000b disables it.
// - Route bit 0 connects clock pin, bit 4 flow pin.
// - Routed clock pin outputs internal clock, inputs external clock.
// - Flow pin is clear-to-send input or request-to-send output.
// - Request-to-send low when ready, high at first drive edge of the frame.
// - Clear-to-send high mid frame finishes frame, then stops.
// - Mode 000b or receive disable clears receive error flags.
module ssp_sync_serial
  import ssp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe_n,
  input  wire logic        transfer_clock_pin_in,
  output logic             transfer_clock_pin_out,
  output logic             transfer_clock_pin_oe_n,
  input  wire logic        flow_control_pin_in,
  output logic             flow_control_pin_out,
  output logic             flow_control_pin_oe_n,
  output logic             tx_irq,
  output logic             rx_irq
);
  import ssp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] route;
    logic [7:0] mode;
    logic [7:0] divisor;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] txbuf;
    logic [7:0] rxbuf;
    logic       overrun;
    logic       rx_pending;
    logic [4:0] pre_cnt;
    logic [7:0] div_cnt;
    logic       sclk;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic [3:0] bit_cnt;
    logic       busy;
    logic       sdo;
    logic       rts_high;
    logic [2:0] ck_sync;
    logic       ck_state;
    logic [2:0] cts_sync;
    logic       cts_state;
    logic [2:0] rx_sync;
    logic       rx_state;
    logic       tx_irq;
    logic       rx_irq;
    logic [31:0] prdata;
  } ssp_state_t;

  ssp_state_t state;
  ssp_state_t next_state;

  // Bit that leaves the byte next, honoring bit order.
  function automatic logic ssp_out_bit(input logic [7:0] v,
                                       input logic msb);
    return msb ? v[7] : v[0];
  endfunction

  // Shift a received bit into the proper end of the register.
  function automatic logic [7:0] ssp_in_bit(input logic [7:0] v,
                                            input logic b,
                                            input logic msb);
    return msb ? {v[6:0], b} : {b, v[7:1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic enabled;
  logic ext_clk;
  logic clock_polarity_bit;
  logic msb_first;
  logic invert;
  logic flow_on;
  logic cts_mode;
  logic rts_mode;
  logic tick;
  logic clk_now;
  logic clk_prev;
  logic drive_edge;
  logic sample_edge;
  logic start_ok;
  logic apb_wr;
  logic apb_rd;
  logic rd_rxbuf;
  logic [4:0] pre_tc;

  // Decode of configuration fields.
  assign enabled   = (state.mode[2:0] == SSP_MODE_SYNC);
  assign ext_clk   = state.mode[SSP_MD_CLOCK_DIRECTION_BIT];
  assign clock_polarity_bit     = state.ctrl0[SSP_C0_CLOCK_POLARITY_BIT];
  assign msb_first = state.ctrl0[SSP_C0_BIT_ORDER_SELECT];
  assign invert    = state.ctrl1[SSP_C1_LCH];
  assign flow_on   = state.route[SSP_RT_FLOW] & ~state.ctrl0[SSP_C0_CRD];
  assign cts_mode  = flow_on & ~state.ctrl0[SSP_C0_CRS];
  assign rts_mode  = flow_on & state.ctrl0[SSP_C0_CRS];
  assign apb_wr    = psel & penable & pwrite;
  assign apb_rd    = psel & penable & ~pwrite;
  assign rd_rxbuf  = apb_rd & (paddr == SSP_ADDR_RXBUF);

  // Count source select: f1, f8, f32 or fC.
  always_comb begin
    case (state.ctrl0[SSP_C0_SRC +: 2])
      2'h0:    pre_tc = 5'h00;
      2'h1:    pre_tc = SSP_PRE_F8;
      2'h2:    pre_tc = SSP_PRE_F32;
      default: pre_tc = SSP_PRE_FC;
    endcase
  end

  // Clock level as seen by the shifter, internal or synchronised pin.
  assign clk_now  = ext_clk ? state.ck_state : state.sclk;
  assign clk_prev = ext_clk ? state.ck_sync[2] : ~state.sclk;
  assign drive_edge  = ext_clk
    ? (state.ck_sync[1] == state.ck_sync[2]) &&
      (state.ck_sync[1] != state.ck_state) && (state.ck_sync[1] == clock_polarity_bit)
    : tick && (state.sclk != clock_polarity_bit);
  assign sample_edge = ext_clk
    ? (state.ck_sync[1] == state.ck_sync[2]) &&
      (state.ck_sync[1] != state.ck_state) && (state.ck_sync[1] != clock_polarity_bit)
    : tick && (state.sclk == clock_polarity_bit);

  // Start only with transmit enabled, data buffered and clear-to-send low.
  assign start_ok = enabled && state.ctrl1[SSP_C1_TE] &&
                    !state.ctrl1[SSP_C1_TI] &&
                    !(cts_mode && state.cts_state);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, divider and shifter.
  always_comb begin
    next_state = state;
    next_state.tx_irq = 1'b0;
    next_state.rx_irq = 1'b0;
    tick = 1'b0;
    // Three-stage pin synchronisers; a level counts once stages 2 and 3 agree.
    next_state.ck_sync  = {state.ck_sync[1:0], transfer_clock_pin_in};
    next_state.cts_sync = {state.cts_sync[1:0], flow_control_pin_in};
    next_state.rx_sync  = {state.rx_sync[1:0], serial_data_in};
    if (state.ck_sync[1] == state.ck_sync[2]) begin
      next_state.ck_state = state.ck_sync[2];
    end
    if (state.cts_sync[1] == state.cts_sync[2]) begin
      next_state.cts_state = state.cts_sync[2];
    end
    if (state.rx_sync[1] == state.rx_sync[2]) begin
      next_state.rx_state = state.rx_sync[2];
    end
    // Rate divider: half period of (n+1) count source ticks.
    if (state.busy && !ext_clk) begin
      if (state.pre_cnt == pre_tc) begin
        next_state.pre_cnt = 5'h00;
        if (state.div_cnt == state.divisor) begin
          next_state.div_cnt = 8'h00;
          tick = 1'b1;
        end else begin
          next_state.div_cnt = state.div_cnt + 8'h01;
        end
      end else begin
        next_state.pre_cnt = state.pre_cnt + 5'h01;
      end
    end else begin
      next_state.pre_cnt = 5'h00;
      next_state.div_cnt = 8'h00;
      next_state.sclk    = ~clock_polarity_bit;
    end
    if (tick) begin
      next_state.sclk = ~state.sclk;
    end
    // Load the shift register when start conditions hold.
    if (!state.busy && start_ok) begin
      next_state.busy     = 1'b1;
      next_state.tx_shift = state.txbuf ^ {8{invert}};
      next_state.bit_cnt  = 4'h0;
      next_state.ctrl1[SSP_C1_TI] = 1'b1;
      next_state.sclk     = ~clock_polarity_bit;
      if (!state.ctrl1[SSP_C1_IRS]) begin
        next_state.tx_irq = 1'b1;
      end
      // First bit goes out before the first clock edge.
      next_state.sdo = ssp_out_bit(state.txbuf ^ {8{invert}}, msb_first);
      next_state.rts_high = 1'b0;
    end else if (state.busy) begin
      // Drive edge: present the next bit; RTS rises at the first one.
      if (drive_edge) begin
        if (state.bit_cnt != 4'h0) begin
          next_state.sdo = ssp_out_bit(state.tx_shift, msb_first);
        end
        if (state.bit_cnt == 4'h0 && clk_now != clk_prev) begin
          next_state.rts_high = 1'b1;
        end
        if (state.bit_cnt == 4'h0) begin
          next_state.rts_high = 1'b1;
        end
      end
      // Sample edge: capture input, advance shifter.
      if (sample_edge) begin
        next_state.rx_shift = ssp_in_bit(state.rx_shift,
                                         state.rx_state ^ invert,
                                         msb_first);
        next_state.tx_shift = msb_first ? {state.tx_shift[6:0], 1'b0}
                                        : {1'b0, state.tx_shift[7:1]};
        next_state.bit_cnt = state.bit_cnt + 4'h1;
        if (state.bit_cnt + 4'h1 == SSP_OVR_BIT && state.rx_pending &&
            state.ctrl1[SSP_C1_RE]) begin
          next_state.overrun = 1'b1;
        end
        if (state.bit_cnt + 4'h1 == SSP_FRAME_BITS) begin
          // Clear-to-send is rechecked before the next frame starts.
          next_state.busy = 1'b0;
          if (state.ctrl1[SSP_C1_IRS]) begin
            next_state.tx_irq = 1'b1;
          end
          if (state.ctrl1[SSP_C1_RE]) begin
            next_state.rxbuf = ssp_in_bit(state.rx_shift,
                                          state.rx_state ^ invert,
                                          msb_first);
            if (!state.rx_pending) begin
              next_state.rx_pending = 1'b1;
              next_state.ctrl1[SSP_C1_RI] = 1'b1;
              next_state.rx_irq = 1'b1;
            end
          end
        end
      end
    end
    // Leaving mode 001b or a cleared transmit enable stops the shifter.
    if (!enabled || !state.ctrl1[SSP_C1_TE]) begin
      next_state.busy = 1'b0;
      next_state.sdo  = 1'b1;
    end
    // APB writes.
    if (apb_wr) begin
      case (paddr)
        SSP_ADDR_ROUTE: next_state.route   = pwdata[7:0];
        SSP_ADDR_MODE:  next_state.mode    = pwdata[7:0];
        SSP_ADDR_DIV:   next_state.divisor = pwdata[7:0];
        SSP_ADDR_CTRL0: next_state.ctrl0   =
          {pwdata[7:4], state.ctrl0[SSP_C0_SHIFT_REG_EMPTY_FLAG], pwdata[2:0]};
        SSP_ADDR_CTRL1: next_state.ctrl1   =
          {pwdata[7:4], next_state.ctrl1[SSP_C1_RI], pwdata[2],
           next_state.ctrl1[SSP_C1_TI], pwdata[0]};
        SSP_ADDR_TXBUF: begin
          next_state.txbuf = pwdata[7:0];
          if (!(!state.busy && start_ok)) begin
            next_state.ctrl1[SSP_C1_TI] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Receive buffer read frees the buffer; continuous mode rearms.
    if (rd_rxbuf) begin
      if (!(next_state.rx_irq)) begin
        next_state.rx_pending = 1'b0;
        next_state.ctrl1[SSP_C1_RI] = 1'b0;
      end
      if (state.ctrl1[SSP_C1_RRM] && !(!state.busy && start_ok)) begin
        next_state.ctrl1[SSP_C1_TI] = 1'b0;
      end
    end
    // Error flags clear on mode off or receive disable.
    if (next_state.mode[2:0] == SSP_MODE_OFF ||
        !next_state.ctrl1[SSP_C1_RE]) begin
      next_state.overrun = 1'b0;
    end
    // Shift register empty flag mirrors the shifter.
    next_state.ctrl0[SSP_C0_SHIFT_REG_EMPTY_FLAG] = ~next_state.busy;
    // Registered read data.
    next_state.prdata = 32'h0000_0000;
    case (paddr)
      SSP_ADDR_ROUTE: next_state.prdata[7:0] = state.route;
      SSP_ADDR_MODE:  next_state.prdata[7:0] = state.mode;
      SSP_ADDR_DIV:   next_state.prdata[7:0] = state.divisor;
      SSP_ADDR_CTRL0: next_state.prdata[7:0] = state.ctrl0;
      SSP_ADDR_CTRL1: next_state.prdata[7:0] = state.ctrl1;
      SSP_ADDR_TXBUF: next_state.prdata[7:0] = state.txbuf;
      SSP_ADDR_RXBUF: begin
        next_state.prdata[7:0] = state.rxbuf;
        next_state.prdata[SSP_RB_OER] = state.overrun;
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= '0;
      state.ctrl1 <= SSP_RST_CTRL1;
      state.ctrl0 <= 8'h08;
      state.sdo   <= 1'b1;
      state.sclk  <= 1'b1;
      state.rts_high <= 1'b1;
      state.ck_sync  <= 3'h7;
      state.ck_state <= 1'b1;
      state.cts_sync <= 3'h7;
      state.cts_state <= 1'b1;
      state.rx_sync  <= 3'h7;
      state.rx_state <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answers: setup cycle captures read data, access completes at once.
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = state.prdata;

  // Pins: data holds its last bit between frames; high bits float in open-drain mode.
  assign serial_data_out      = state.sdo;
  assign serial_data_out_oe_n = !enabled ||
    (state.ctrl0[SSP_C0_NCH] && state.sdo);
  assign transfer_clock_pin_out = state.sclk;
  assign transfer_clock_pin_oe_n = !(state.route[SSP_RT_CLK] && enabled &&
                                     !ext_clk);
  assign flow_control_pin_out  = state.busy ? state.rts_high :
    !(enabled && state.ctrl1[SSP_C1_RE]);
  assign flow_control_pin_oe_n = !(rts_mode && enabled);
  assign tx_irq = state.tx_irq;
  assign rx_irq = state.rx_irq;

endmodule // ssp_sync_serial

// file: verilog/ssp_pkg.sv
// Package for the clock synchronous serial port block.
// Assumes a 25 MHz APB clock and 32-bit APB data with one register per word.
package ssp_pkg;
  // Register byte offsets.
  localparam logic [11:0] SSP_OFF_ROUTE   = 12'h018b;
  localparam logic [11:0] SSP_ADDR_ROUTE  = 12'h062c;
  localparam logic [11:0] SSP_ADDR_MODE   = 12'h0600;
  localparam logic [11:0] SSP_ADDR_DIV    = 12'h0604;
  localparam logic [11:0] SSP_ADDR_CTRL0  = 12'h0608;
  localparam logic [11:0] SSP_ADDR_CTRL1  = 12'h060c;
  localparam logic [11:0] SSP_ADDR_TXBUF  = 12'h0610;
  localparam logic [11:0] SSP_ADDR_RXBUF  = 12'h0614;
  // Mode field codes.
  localparam logic [2:0]  SSP_MODE_OFF    = 3'h0;
  localparam logic [2:0]  SSP_MODE_SYNC   = 3'h1;
  // Route register bit positions.
  localparam int          SSP_RT_CLK      = 0;
  localparam int          SSP_RT_FLOW     = 4;
  // Mode register bit positions.
  localparam int          SSP_MD_CLOCK_DIRECTION_BIT    = 3;
  // Control 0 bit positions.
  localparam int          SSP_C0_SRC      = 0;
  localparam int          SSP_C0_CRS      = 2;
  localparam int          SSP_C0_SHIFT_REG_EMPTY_FLAG    = 3;
  localparam int          SSP_C0_CRD      = 4;
  localparam int          SSP_C0_NCH      = 5;
  localparam int          SSP_C0_CLOCK_POLARITY_BIT    = 6;
  localparam int          SSP_C0_BIT_ORDER_SELECT    = 7;
  // Control 1 bit positions.
  localparam int          SSP_C1_TE       = 0;
  localparam int          SSP_C1_TI       = 1;
  localparam int          SSP_C1_RE       = 2;
  localparam int          SSP_C1_RI       = 3;
  localparam int          SSP_C1_IRS      = 4;
  localparam int          SSP_C1_RRM      = 5;
  localparam int          SSP_C1_LCH      = 6;
  // Receive buffer overrun flag position.
  localparam int          SSP_RB_OER      = 12;
  // Frame length and overrun bit count.
  localparam logic [3:0]  SSP_FRAME_BITS  = 4'h8;
  localparam logic [3:0]  SSP_OVR_BIT     = 4'h7;
  // Prescaler ratios for the three divided count sources, as terminal counts.
  localparam logic [4:0]  SSP_PRE_F8      = 5'h07;
  localparam logic [4:0]  SSP_PRE_F32     = 5'h1f;
  localparam logic [4:0]  SSP_PRE_FC      = 5'h0f;
  // Reset values.
  localparam logic [7:0]  SSP_RST_BYTE    = 8'h00;
  localparam logic [7:0]  SSP_RST_CTRL1   = 8'h02;
endpackage

// file: verification/ssp_props.sv
// Checker for the synchronous serial port, watching its top ports only.
// Assumes APB writes take effect where psel, penable and pready are high.
`timescale 1ns/1ps
module ssp_props
  import ssp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        serial_data_out_oe_n,
  input wire logic        transfer_clock_pin_out,
  input wire logic        transfer_clock_pin_oe_n,
  input wire logic        flow_control_pin_oe_n,
  input wire logic        tx_irq,
  input wire logic        rx_irq
);
  logic [7:0]  rt_q;
  logic [3:0]  md_q;
  logic [7:0]  dv_q;
  logic [7:0]  c0_q;
  logic [13:0] lo_cnt;
  logic [13:0] half;
  logic [2:0]  shf;
  logic        wr;
  logic        off;
  ////////////////////////////////////////////////////////////////////////
  // Half period of the internal clock from source and divisor shadows.
  assign wr = psel && penable && pwrite && pready;
  assign off = md_q[2:0] != SSP_MODE_SYNC;
  assign shf = c0_q[1] ? (c0_q[0] ? 3'h4 : 3'h5) : (c0_q[0] ? 3'h3 : 3'h0);
  assign half = ({6'h00, dv_q} + 14'h0001) << shf;
  // Shadow the configuration and count low clock cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_q <= 8'h00;
      md_q <= 4'h0;
      dv_q <= 8'h00;
      c0_q <= 8'h00;
      lo_cnt <= 14'h0000;
    end else begin
      if (wr && paddr == SSP_ADDR_ROUTE) rt_q <= pwdata[7:0];
      if (wr && paddr == SSP_ADDR_MODE) md_q <= pwdata[3:0];
      if (wr && paddr == SSP_ADDR_DIV) dv_q <= pwdata[7:0];
      if (wr && paddr == SSP_ADDR_CTRL0) c0_q <= pwdata[7:0];
      lo_cnt <= (transfer_clock_pin_out || c0_q[6]) ? 14'h0000
                                                     : lo_cnt + 14'h0001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  AST_TX_PULSE: assert property (tx_irq |=> !tx_irq)
    else $error("transmit request longer than one cycle");
  AST_RX_PULSE: assert property (rx_irq |=> !rx_irq)
    else $error("receive request longer than one cycle");
  AST_RATE: assert property ($rose(transfer_clock_pin_out)
    && !transfer_clock_pin_oe_n && !$past(c0_q[6], 4) |-> lo_cnt == half)
    else $error("internal clock low phase has wrong length");
  AST_CLK_OFF: assert property (off [*2] |-> transfer_clock_pin_oe_n)
    else $error("clock pin driven while port disabled");
  AST_CLK_ON: assert property ((rt_q[0] && !off && !md_q[3]) [*2]
    |-> !transfer_clock_pin_oe_n)
    else $error("routed internal clock not driven");
  AST_DOUT_OFF: assert property (off [*2] |-> serial_data_out_oe_n)
    else $error("data out driven while port disabled");
  AST_FLOW_RTS: assert property ((rt_q[4] && !c0_q[4] && c0_q[2] && !off) [*2]
    |-> !flow_control_pin_oe_n)
    else $error("request-to-send pin not driven");
  AST_FLOW_CTS: assert property ((rt_q[4] && !c0_q[4] && !c0_q[2]) [*2]
    |-> flow_control_pin_oe_n)
    else $error("clear-to-send pin driven");
  AST_IRQ_OFF: assert property (off [*2] |-> !tx_irq && !rx_irq)
    else $error("request while port disabled");
endmodule // ssp_props

bind ssp_sync_serial ssp_props ssp_props_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .serial_data_out_oe_n, .transfer_clock_pin_out, .transfer_clock_pin_oe_n,
  .flow_control_pin_oe_n, .tx_irq, .rx_irq
);

// file: verification/ssp_peer.sv
// Behavioural far-side peer of the synchronous serial port.
// Assumes sclk is the transfer clock on the wire; pol matches polarity bit.
`timescale 1ns/1ps
module ssp_peer (
  input  wire logic       rst_n,
  input  wire logic       sclk,
  input  wire logic       pol,
  input  wire logic       sdo,
  input  wire logic [7:0] tx_byte,
  output logic            sdi,
  output logic [7:0]      rx_byte
);
  logic       eff;
  logic [2:0] nbit;
  // Polarity one swaps the driving and sampling edges.
  assign eff = sclk ^ pol;
  // Drive the next bit on the falling edge of eff; sample eight bits on
  // its rising edge, the first landing in bit 0, then spoil the line.
  always @(posedge eff or negedge eff or negedge rst_n) begin
    if (!rst_n) begin
      sdi <= 1'b1;
      nbit <= 3'h0;
      rx_byte <= 8'h00;
    end else if (!eff) begin
      sdi <= tx_byte[nbit];
    end else begin
      rx_byte <= {sdo, rx_byte[7:1]};
      nbit <= nbit + 3'h1;
      if (nbit == 3'h7) sdi <= ~sdi;
    end
  end
endmodule // ssp_peer

// file: verification/test_sync_serial_port_mode.sv
// Self-checking bench of the synchronous serial port over APB.
// Assumes the peer model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module test_sync_serial_port_mode;
  import ssp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, sdi, sdo, sdo_oe_n, clk_o, clk_oe_n, cts_n = 0;
  logic fl_o, fl_oe_n, tx_irq, rx_irq, pol = 0, peer_rst_n = 0;
  logic ext_ck = 1, ext_mode = 0;
  logic [7:0] peer_tx = 8'h00, peer_rx;
  int fail_count = 0, checks_done = 0, tx_cnt = 0, rx_cnt = 0;
  ////////////////////////////////////////////////////////////////////////
  ssp_sync_serial ssp_sync_serial_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(),
    .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_out_oe_n(sdo_oe_n), .transfer_clock_pin_in(ext_ck),
    .transfer_clock_pin_out(clk_o), .transfer_clock_pin_oe_n(clk_oe_n),
    .flow_control_pin_in(cts_n), .flow_control_pin_out(fl_o),
    .flow_control_pin_oe_n(fl_oe_n), .tx_irq, .rx_irq);
  ssp_peer ssp_peer_i (.rst_n(peer_rst_n), .sclk(ext_mode ? ext_ck : clk_o),
    .pol, .sdo, .tx_byte(peer_tx), .sdi, .rx_byte(peer_rx));
  // Clock at 25 MHz and request tallies taken away from the sampling edge.
  always #20 pclk = ~pclk;
  always @(negedge pclk) begin
    if (tx_irq === 1'b1) tx_cnt++;
    if (rx_irq === 1'b1) rx_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; setup lasts one cycle, access is held until pready is high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    cmp(q & m, e);
  endtask
  task automatic xfer(input logic [7:0] d, input logic [7:0] pd);
    peer_tx <= pd;
    wr(SSP_ADDR_TXBUF, {24'h00_0000, d});
  endtask
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (rx_cnt < n && k < 1000) begin
      k++;
      @(posedge pclk);
    end
    cmp(rx_cnt, n);
  endtask
  task automatic peer_pol(input logic p);
    pol <= p;
    peer_rst_n <= 1'b0;
    repeat (3) @(posedge pclk);
    peer_rst_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog well past the expected run length.
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    results();
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    peer_rst_n <= 1'b1;
    chk(SSP_ADDR_ROUTE, 32'h0000_00ff, 32'h0000_0000);
    chk(SSP_ADDR_CTRL1, 32'h0000_00ff, SSP_RST_CTRL1);
    chk(SSP_ADDR_CTRL0, 32'h0000_0008, 32'h0000_0008);
    chk(12'h700, 32'hffff_ffff, 32'h0000_0000);
    cmp(sdo_oe_n, 1'b1);
    wr(SSP_ADDR_ROUTE, 32'h0000_0011);
    wr(SSP_ADDR_MODE, 32'h0000_0001);
    wr(SSP_ADDR_DIV, 32'h0000_0007);
    wr(SSP_ADDR_CTRL0, 32'h0000_0000);
    wr(SSP_ADDR_CTRL1, 32'h0000_0005);
    cmp({sdo, sdo_oe_n, clk_oe_n, fl_oe_n}, 4'b1001);
    xfer(8'h3a, 8'hc1);
    repeat (3) @(posedge pclk);
    cmp(tx_cnt, 1);
    chk(SSP_ADDR_CTRL0, 32'h0000_0008, 32'h0000_0000);
    chk(SSP_ADDR_CTRL1, 32'h0000_0002, 32'h0000_0002);
    wait_rx(1);
    cmp(peer_rx, 8'h3a);
    chk(SSP_ADDR_CTRL1, 32'h0000_0008, 32'h0000_0008);
    chk(SSP_ADDR_RXBUF, 32'h0000_00ff, 32'h0000_00c1);
    // MSB first, polarity one, inverted data, request at shift end.
    wr(SSP_ADDR_CTRL0, 32'h0000_00c0);
    wr(SSP_ADDR_CTRL1, 32'h0000_0055);
    peer_pol(1'b1);
    xfer(8'h3a, 8'hc1);
    repeat (3) @(posedge pclk);
    cmp(tx_cnt, 1);
    wait_rx(2);
    repeat (4) @(posedge pclk);
    cmp(tx_cnt, 2);
    cmp(peer_rx, 8'ha3);
    chk(SSP_ADDR_RXBUF, 32'h0000_00ff, 32'h0000_007c);
    // Two frames without a buffer read give an overrun.
    wr(SSP_ADDR_CTRL0, 32'h0000_0000);
    wr(SSP_ADDR_CTRL1, 32'h0000_0005);
    peer_pol(1'b0);
    xfer(8'h55, 8'h0f);
    wait_rx(3);
    xfer(8'h55, 8'hf0);
    repeat (300) @(posedge pclk);
    cmp(rx_cnt, 3);
    chk(SSP_ADDR_RXBUF, 32'h0000_1000, 32'h0000_1000);
    wr(SSP_ADDR_CTRL1, 32'h0000_0001);
    chk(SSP_ADDR_RXBUF, 32'h0000_1000, 32'h0000_0000);
    // Clear-to-send high holds the start; count source f32, divisor 0.
    cts_n <= 1'b1;
    wr(SSP_ADDR_DIV, 32'h0000_0000);
    wr(SSP_ADDR_CTRL0, 32'h0000_0002);
    wr(SSP_ADDR_CTRL1, 32'h0000_0005);
    xfer(8'h81, 8'h18);
    repeat (200) @(posedge pclk);
    cmp(tx_cnt, 4);
    chk(SSP_ADDR_CTRL0, 32'h0000_0008, 32'h0000_0008);
    cts_n <= 1'b0;
    wait_rx(4);
    cmp(peer_rx, 8'h81);
    // A buffer read in continuous mode starts the next reception.
    peer_tx <= 8'h66;
    wr(SSP_ADDR_CTRL1, 32'h0000_0025);
    chk(SSP_ADDR_RXBUF, 32'h0000_00ff, 32'h0000_0018);
    wait_rx(5);
    chk(SSP_ADDR_RXBUF, 32'h0000_00ff, 32'h0000_0066);
    wr(SSP_ADDR_CTRL0, 32'h0000_0006);
    repeat (2) @(posedge pclk);
    cmp(fl_oe_n, 1'b0);
    wr(SSP_ADDR_CTRL1, 32'h0000_0000);
    wr(SSP_ADDR_MODE, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    cmp({clk_oe_n, sdo_oe_n}, 2'b11);
    // Recovery into external clock mode; the peer clock idles high.
    ext_mode <= 1'b1;
    peer_pol(1'b0);
    wr(SSP_ADDR_MODE, 32'h0000_0009);
    wr(SSP_ADDR_CTRL1, 32'h0000_0005);
    xfer(8'h5c, 8'h2b);
    repeat (8) begin
      repeat (8) @(posedge pclk);
      ext_ck <= 1'b0;
      repeat (8) @(posedge pclk);
      ext_ck <= 1'b1;
    end
    wait_rx(6);
    cmp({clk_oe_n, peer_rx}, {1'b1, 8'h5c});
    chk(SSP_ADDR_RXBUF, 32'h0000_00ff, 32'h0000_002b);
    results();
  end
endmodule // test_sync_serial_port_mode
